// ### rtl/sideband_regs.svh
`ifndef SIDEBAND_REGS_SVH
`define SIDEBAND_REGS_SVH

`define REF_CLK_MHZ 100
`define SCL_PERIOD_NS 2500
`define SCL_QUARTER_CYCLES (((`SCL_PERIOD_NS / 4) * `REF_CLK_MHZ) / 1000)
`define RESET_MIN_NS 10000
`define RESET_MIN_CYCLES ((`RESET_MIN_NS * `REF_CLK_MHZ + 999) / 1000)
`define HOST_RESET_NS 20000
`define HOST_RESET_CYCLES ((`HOST_RESET_NS * `REF_CLK_MHZ) / 1000)

`define TWI_DEV_ADDR 7'h50
`define BIT_CNT_FULL 4'h8

`define MAP_STATUS 8'h02
`define MAP_FLAGS 8'h03
`define MAP_CONTROL 8'h5D
`define MAP_LAST 8'hFF
`define MAP_DEFAULT 8'h00
`define CONTROL_DEFAULT 8'h00
`define STATUS_PENDING_BIT 0
`define FLAG_RESET_DONE_BIT 0
`define FLAG_FAULT_BIT 1
`define FLAG_W 2
`define CTRL_FORCE_LP_BIT 0

`define SYNC_SCL 0
`define SYNC_SDA 1
`define SYNC_SEL 2
`define SYNC_RST 3
`define SYNC_LP 4
`define SYNC_W 5
`define SYNC_RESET_VAL 5'h1F

`define HSYNC_SDA 0
`define HSYNC_PRS 1
`define HSYNC_INT 2
`define HSYNC_W 3
`define HSYNC_RESET_VAL 3'h7

`define HSTEP_START 3'h0
`define HSTEP_ADDR 3'h1
`define HSTEP_REG 3'h2
`define HSTEP_MID 3'h3
`define HSTEP_LASTW 3'h4
`define HSTEP_RBYTE 3'h5
`define HSTEP_STOP_R 3'h6

`endif

// ### rtl/sideband_pkg.sv
package sideband_pkg;
  typedef enum logic [2:0] {
    TW_IDLE, TW_DEVADDR, TW_ACK, TW_REGADDR, TW_WDATA, TW_RDATA, TW_RACK
  } twi_state_t;
  typedef enum logic [1:0] {M_INIT, M_RUN, M_HELD} module_state_t;
  typedef enum logic [1:0] {OP_START, OP_WBYTE, OP_RBYTE, OP_STOP} host_op_t;
endpackage

// ### rtl/sideband_if.sv
`timescale 1ns/1ps
interface sideband_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic mod_sda_out;
  logic mod_sda_oe;
  logic mod_int_out;
  logic mod_int_oe;
  logic mod_presence_out;
  logic mod_presence_oe;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic scl;
  logic sda;
  logic presence_n;
  logic interrupt_n;

  // pull-ups on the host board resolve every open-drain line
  assign scl = host_scl_oe ? host_scl_out : 1'b1;
  assign sda = (host_sda_oe ? host_sda_out : 1'b1) & (mod_sda_oe ? mod_sda_out : 1'b1);
  assign presence_n = mod_presence_oe ? mod_presence_out : 1'b1;
  assign interrupt_n = mod_int_oe ? mod_int_out : 1'b1;

  modport module_mp (
    input scl, sda, module_select_n, module_reset_n, low_power_select,
    output mod_sda_out, mod_sda_oe, mod_int_out, mod_int_oe,
    output mod_presence_out, mod_presence_oe
  );
  modport host_mp (
    input scl, sda, presence_n, interrupt_n,
    output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe,
    output module_select_n, module_reset_n, low_power_select
  );
endinterface

// ### rtl/twi_target.sv
`timescale 1ns/1ps
`include "sideband_regs.svh"
module twi_target (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] rdata_in,
  output logic sda_oe_out,
  output logic [7:0] ptr_out,
  output logic rd_out,
  output logic wr_out,
  output logic [7:0] waddr_out,
  output logic [7:0] wdata_out
);
  sideband_pkg::twi_state_t state_q;
  sideband_pkg::twi_state_t next_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign rise = scl_in & ~scl_q;
  assign fall = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop = scl_in & scl_q & ~sda_q & sda_in;

  ////////////////////////////////////////////////////////////////////////////
  // sample on scl rise, drive on scl fall: sda never moves while scl is high
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= sideband_pkg::TW_IDLE;
      next_q <= sideband_pkg::TW_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_out <= 8'h00;
      sda_oe_out <= 1'b0;
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      waddr_out <= 8'h00;
      wdata_out <= 8'h00;
    end else begin
      rd_out <= 1'b0;
      wr_out <= 1'b0;
      if (!enable_in || stop) begin
        state_q <= sideband_pkg::TW_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start) begin
        state_q <= sideband_pkg::TW_DEVADDR;
        cnt_q <= 4'h0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_q)
          sideband_pkg::TW_DEVADDR, sideband_pkg::TW_REGADDR, sideband_pkg::TW_WDATA: begin
            if (rise) begin
              shift_q <= {shift_q[6:0], sda_in};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == `BIT_CNT_FULL) begin
              cnt_q <= 4'h0;
              sda_oe_out <= 1'b1;
              state_q <= sideband_pkg::TW_ACK;
              next_q <= sideband_pkg::TW_WDATA;
              if (state_q == sideband_pkg::TW_DEVADDR) begin
                next_q <= shift_q[0] ? sideband_pkg::TW_RDATA : sideband_pkg::TW_REGADDR;
                if (shift_q[7:1] != `TWI_DEV_ADDR) begin
                  sda_oe_out <= 1'b0;
                  state_q <= sideband_pkg::TW_IDLE;
                end
              end else if (state_q == sideband_pkg::TW_REGADDR) begin
                ptr_out <= shift_q;
              end else begin
                wr_out <= 1'b1;
                waddr_out <= ptr_out;
                wdata_out <= shift_q;
                ptr_out <= ptr_out + 8'h01;
              end
            end
          end
          sideband_pkg::TW_ACK: begin
            if (fall) begin
              if (next_q == sideband_pkg::TW_RDATA) begin
                shift_q <= rdata_in;
                rd_out <= 1'b1;
                sda_oe_out <= ~rdata_in[7];
              end else begin
                sda_oe_out <= 1'b0;
              end
              state_q <= next_q;
            end
          end
          sideband_pkg::TW_RDATA: begin
            if (rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (fall) begin
              if (cnt_q == `BIT_CNT_FULL) begin
                cnt_q <= 4'h0;
                sda_oe_out <= 1'b0;
                state_q <= sideband_pkg::TW_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b1};
                sda_oe_out <= ~shift_q[6];
              end
            end
          end
          sideband_pkg::TW_RACK: begin
            if (rise) begin
              if (sda_in) begin
                state_q <= sideband_pkg::TW_IDLE;
              end else begin
                ptr_out <= ptr_out + 8'h01;
              end
            end else if (fall) begin
              shift_q <= rdata_in;
              rd_out <= 1'b1;
              sda_oe_out <= ~rdata_in[7];
              state_q <= sideband_pkg::TW_RDATA;
            end
          end
          default: begin
            sda_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // twi_target

// ### rtl/module_end.sv
`timescale 1ns/1ps
`include "sideband_regs.svh"
module module_end #(
  parameter int RESET_MIN_CYCLES = `RESET_MIN_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  sideband_if.module_mp link,
  input wire logic fault_in,
  output logic power_limit_low_out,
  output logic [7:0] control_out,
  output logic in_reset_out,
  output logic status_pending_out
);
  logic [`SYNC_W-1:0] s1_q;
  logic [`SYNC_W-1:0] s2_q;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic rst_s;
  logic lp_s;
  sideband_pkg::module_state_t mstate_q;
  logic [15:0] low_cnt_q;
  logic long_low;
  logic [7:0] idx_q;
  logic reset_done;
  logic [7:0] mem [0:255];
  logic pending_q;
  logic [`FLAG_W-1:0] flags_q;
  logic [`FLAG_W-1:0] flag_set;
  logic [`FLAG_W-1:0] flag_clr;
  logic [7:0] status_byte;
  logic [7:0] flag_byte;
  logic [7:0] rdata;
  logic twi_enable;
  logic twi_sda_oe;
  logic [7:0] twi_ptr;
  logic twi_rd;
  logic twi_wr;
  logic [7:0] twi_waddr;
  logic [7:0] twi_wdata;
  logic map_write;
  logic int_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // every pin crosses two flops before any logic looks at it
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_q <= `SYNC_RESET_VAL;
      s2_q <= `SYNC_RESET_VAL;
    end else begin
      s1_q <= {link.low_power_select, link.module_reset_n, link.module_select_n,
               link.sda, link.scl};
      s2_q <= s1_q;
    end
  end

  assign scl_s = s2_q[`SYNC_SCL];
  assign sda_s = s2_q[`SYNC_SDA];
  assign sel_s = s2_q[`SYNC_SEL];
  assign rst_s = s2_q[`SYNC_RST];
  assign lp_s = s2_q[`SYNC_LP];

  ////////////////////////////////////////////////////////////////////////////
  // low time counter saturates, so a long hold costs nothing extra
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_cnt_q <= 16'h0000;
    end else if (rst_s) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'(RESET_MIN_CYCLES)) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end

  assign long_low = ~rst_s && low_cnt_q == 16'(RESET_MIN_CYCLES);

  ////////////////////////////////////////////////////////////////////////////
  // init sweeps the whole map one byte a cycle; power-up starts here too
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mstate_q <= sideband_pkg::M_INIT;
      idx_q <= 8'h00;
    end else begin
      case (mstate_q)
        sideband_pkg::M_INIT: begin
          idx_q <= idx_q + 8'h01;
          if (long_low) begin
            mstate_q <= sideband_pkg::M_HELD;
          end else if (idx_q == `MAP_LAST) begin
            mstate_q <= sideband_pkg::M_RUN;
          end
        end
        sideband_pkg::M_RUN: begin
          if (long_low) begin
            mstate_q <= sideband_pkg::M_HELD;
          end
        end
        sideband_pkg::M_HELD: begin
          idx_q <= 8'h00;
          if (rst_s) begin
            mstate_q <= sideband_pkg::M_INIT;
          end
        end
        default: begin
          mstate_q <= sideband_pkg::M_INIT;
        end
      endcase
    end
  end

  assign reset_done = mstate_q == sideband_pkg::M_INIT && idx_q == `MAP_LAST && ~long_low;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      in_reset_out <= 1'b1;
    end else begin
      in_reset_out <= ~(mstate_q == sideband_pkg::M_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the bus stays dead during reset, so status read mid-reset is never stale
  assign twi_enable = ~sel_s && mstate_q == sideband_pkg::M_RUN;

  twi_target u_twi (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .enable_in(twi_enable),
    .scl_in(scl_s),
    .sda_in(sda_s),
    .rdata_in(rdata),
    .sda_oe_out(twi_sda_oe),
    .ptr_out(twi_ptr),
    .rd_out(twi_rd),
    .wr_out(twi_wr),
    .waddr_out(twi_waddr),
    .wdata_out(twi_wdata)
  );

  assign link.mod_sda_out = 1'b0;
  assign link.mod_sda_oe = twi_sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // status and flag bytes are read-only; writes to them are dropped
  assign map_write = twi_wr && twi_waddr != `MAP_STATUS && twi_waddr != `MAP_FLAGS;

  always_ff @(posedge ref_clk_in) begin
    if (mstate_q == sideband_pkg::M_INIT) begin
      mem[idx_q] <= `MAP_DEFAULT;
    end else if (map_write) begin
      mem[twi_waddr] <= twi_wdata;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control_out <= `CONTROL_DEFAULT;
    end else if (mstate_q != sideband_pkg::M_RUN) begin
      control_out <= `CONTROL_DEFAULT;
    end else if (map_write && twi_waddr == `MAP_CONTROL) begin
      control_out <= twi_wdata;
    end
  end

  always_comb begin
    status_byte = '0;
    status_byte[`STATUS_PENDING_BIT] = pending_q;
    flag_byte = '0;
    flag_byte[`FLAG_W-1:0] = flags_q;
    if (twi_ptr == `MAP_STATUS) begin
      rdata = status_byte;
    end else if (twi_ptr == `MAP_FLAGS) begin
      rdata = flag_byte;
    end else begin
      rdata = mem[twi_ptr];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pending_q <= 1'b1;
    end else if (reset_done) begin
      pending_q <= 1'b0;
    end else if (mstate_q != sideband_pkg::M_RUN) begin
      pending_q <= 1'b1;
    end
  end

  assign status_pending_out = pending_q;

  // clear on read of the flag byte; a new event in that cycle still lands
  always_comb begin
    flag_set = '0;
    flag_set[`FLAG_RESET_DONE_BIT] = reset_done;
    flag_set[`FLAG_FAULT_BIT] = fault_in && mstate_q == sideband_pkg::M_RUN;
    flag_clr = '0;
    if (twi_rd && twi_ptr == `MAP_FLAGS) begin
      flag_clr = '1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      flags_q <= '0;
    end else if (mstate_q == sideband_pkg::M_HELD) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain: the data level is fixed low, only the enable moves
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= |flags_q;
    end
  end

  assign link.mod_int_out = 1'b0;
  assign link.mod_int_oe = int_oe_q;

  // a fitted module is a fixed path to ground
  assign link.mod_presence_out = 1'b0;
  assign link.mod_presence_oe = 1'b1;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      power_limit_low_out <= 1'b1;
    end else begin
      power_limit_low_out <= lp_s | control_out[`CTRL_FORCE_LP_BIT];
    end
  end
endmodule // module_end

// ### rtl/host_end.sv
`timescale 1ns/1ps
`include "sideband_regs.svh"
module host_end (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  sideband_if.host_mp link,
  input wire logic cmd_valid_in,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_reg_in,
  input wire logic [7:0] cmd_wdata_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic rsp_nack_out,
  output logic [7:0] rsp_rdata_out,
  input wire logic reset_req_in,
  input wire logic low_power_in,
  output logic present_out,
  output logic irq_out,
  output logic status_valid_out
);
  logic [`HSYNC_W-1:0] s1_q;
  logic [`HSYNC_W-1:0] s2_q;
  logic busy_q;
  logic read_q;
  logic [7:0] reg_q;
  logic [7:0] wdata_q;
  logic [15:0] qcnt_q;
  logic tick;
  logic [1:0] phase_q;
  logic [2:0] step_q;
  logic [3:0] bit_q;
  logic [7:0] tx;
  logic scl_low_q;
  logic sda_low_q;
  logic rst_low_q;
  logic [15:0] rst_cnt_q;
  logic reset_wait_q;
  sideband_pkg::host_op_t op;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_q <= `HSYNC_RESET_VAL;
      s2_q <= `HSYNC_RESET_VAL;
    end else begin
      s1_q <= {link.interrupt_n, link.presence_n, link.sda};
      s2_q <= s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (step_q)
      `HSTEP_START: op = sideband_pkg::OP_START;
      `HSTEP_MID: op = read_q ? sideband_pkg::OP_START : sideband_pkg::OP_WBYTE;
      `HSTEP_LASTW: op = read_q ? sideband_pkg::OP_WBYTE : sideband_pkg::OP_STOP;
      `HSTEP_RBYTE: op = read_q ? sideband_pkg::OP_RBYTE : sideband_pkg::OP_STOP;
      `HSTEP_STOP_R: op = sideband_pkg::OP_STOP;
      default: op = sideband_pkg::OP_WBYTE;
    endcase
    case (step_q)
      `HSTEP_ADDR: tx = {`TWI_DEV_ADDR, 1'b0};
      `HSTEP_REG: tx = reg_q;
      `HSTEP_LASTW: tx = {`TWI_DEV_ADDR, 1'b1};
      default: tx = wdata_q;
    endcase
  end

  assign cmd_ready_out = ~busy_q & ~rst_low_q;
  assign tick = busy_q && qcnt_q == 16'(`SCL_QUARTER_CYCLES - 1);

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      qcnt_q <= 16'h0000;
    end else if (!busy_q || tick) begin
      qcnt_q <= 16'h0000;
    end else begin
      qcnt_q <= qcnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // each bit is four quarters: set sda, raise scl, sample, drop scl
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_q <= 1'b0;
      read_q <= 1'b0;
      reg_q <= 8'h00;
      wdata_q <= 8'h00;
      phase_q <= 2'h0;
      step_q <= `HSTEP_START;
      bit_q <= 4'h0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_nack_out <= 1'b0;
      rsp_rdata_out <= 8'h00;
    end else begin
      rsp_valid_out <= 1'b0;
      if (!busy_q) begin
        if (cmd_valid_in && cmd_ready_out) begin
          busy_q <= 1'b1;
          read_q <= cmd_read_in;
          reg_q <= cmd_reg_in;
          wdata_q <= cmd_wdata_in;
          step_q <= `HSTEP_START;
          phase_q <= 2'h0;
          bit_q <= 4'h0;
          rsp_nack_out <= 1'b0;
        end
      end else if (tick) begin
        phase_q <= phase_q + 2'h1;
        case (op)
          sideband_pkg::OP_START: begin
            case (phase_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1;
                step_q <= step_q + 3'h1;
              end
            endcase
          end
          sideband_pkg::OP_STOP: begin
            case (phase_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              default: begin
                busy_q <= 1'b0;
                rsp_valid_out <= 1'b1;
              end
            endcase
          end
          default: begin
            case (phase_q)
              2'h0: sda_low_q <= op == sideband_pkg::OP_WBYTE && !bit_q[3] && !tx[~bit_q[2:0]];
              2'h1: scl_low_q <= 1'b0;
              2'h2: begin
                if (bit_q == `BIT_CNT_FULL) begin
                  rsp_nack_out <= rsp_nack_out | (op == sideband_pkg::OP_WBYTE &&
                                                  s2_q[`HSYNC_SDA]);
                end else if (op == sideband_pkg::OP_RBYTE) begin
                  rsp_rdata_out <= {rsp_rdata_out[6:0], s2_q[`HSYNC_SDA]};
                end
              end
              default: begin
                scl_low_q <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (bit_q == `BIT_CNT_FULL) begin
                  bit_q <= 4'h0;
                  step_q <= step_q + 3'h1;
                  if (rsp_nack_out) begin
                    step_q <= read_q ? `HSTEP_STOP_R : `HSTEP_LASTW;
                  end
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign link.host_scl_out = 1'b0;
  assign link.host_scl_oe = scl_low_q;
  assign link.host_sda_out = 1'b0;
  assign link.host_sda_oe = sda_low_q;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link.module_select_n <= 1'b1;
      link.low_power_select <= 1'b1;
    end else begin
      link.module_select_n <= ~busy_q;
      link.low_power_select <= low_power_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_low_q <= 1'b0;
      rst_cnt_q <= 16'h0000;
    end else if (!rst_low_q) begin
      rst_cnt_q <= 16'h0000;
      rst_low_q <= reset_req_in && !busy_q;
    end else if (rst_cnt_q == 16'(`HOST_RESET_CYCLES - 1)) begin
      rst_low_q <= 1'b0;
    end else begin
      rst_cnt_q <= rst_cnt_q + 16'h0001;
    end
  end

  assign link.module_reset_n = ~rst_low_q;

  // status counts only after the reset-done interrupt; power-up waits too
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reset_wait_q <= 1'b1;
      irq_out <= 1'b0;
      present_out <= 1'b0;
      status_valid_out <= 1'b0;
    end else begin
      if (rst_low_q) begin
        reset_wait_q <= 1'b1;
      end else if (!s2_q[`HSYNC_INT]) begin
        reset_wait_q <= 1'b0;
      end
      irq_out <= ~s2_q[`HSYNC_INT] & ~reset_wait_q;
      present_out <= ~s2_q[`HSYNC_PRS];
      status_valid_out <= ~reset_wait_q;
    end
  end
endmodule // host_end

// ### verif/sideband_assertions.sv
`timescale 1ns/1ps
module sideband_assertions #(
  parameter int RESET_MIN_CYCLES = 8
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic module_select_n,
  input wire logic module_reset_n,
  input wire logic scl,
  input wire logic presence_n,
  input wire logic interrupt_n,
  input wire logic mod_sda_out,
  input wire logic mod_sda_oe,
  input wire logic mod_int_out,
  input wire logic mod_int_oe
);
  int low_q;
  logic long_low;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_q <= 0;
    end else if (module_reset_n) begin
      low_q <= 0;
    end else if (low_q < 4000) begin
      low_q <= low_q + 1;
    end
  end
  // margin covers the pin synchronisers
  assign long_low = low_q > RESET_MIN_CYCLES + 16;
  ////////////////////////////////////////
  AST_SEL: assert property (module_select_n [*6] |-> !mod_sda_oe)
    else $error("sda driven while deselected");
  AST_SDA_EDGE: assert property ($changed(mod_sda_oe) |-> !scl)
    else $error("sda changed while scl high");
  AST_SDA_OD: assert property (mod_sda_oe |-> !mod_sda_out)
    else $error("sda driven high");
  AST_INT_OD: assert property (mod_int_oe |-> !mod_int_out)
    else $error("interrupt driven high");
  AST_PRS: assert property (!presence_n)
    else $error("presence not grounded");
  AST_HOLD: assert property (long_low |-> interrupt_n)
    else $error("interrupt kept during reset");
  AST_DONE: assert property ($rose(module_reset_n) && long_low |-> ##[1:400] !interrupt_n)
    else $error("no reset done interrupt");
  AST_PWRUP: assert property ($rose(resetn_in) |-> interrupt_n [*8] ##[1:400] !interrupt_n)
    else $error("no power-up interrupt");
endmodule // sideband_assertions

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0, rstn = 1'h0, cv = 1'h0, crd = 1'h0, fault = 1'h0, rreq = 1'h0, lp = 1'h0;
  logic [7:0] ca = 8'h00, cd = 8'h00, a, rdat, ctl;
  logic rdy, rv, nk, prs, irq, sv, pl, inr, pnd;
  logic [7:0] mem [256];
  int errors = 0, tests_run = 0, seed = 32'hef01;
  always #5 clk = ~clk;
  sideband_if lk();
  module_end #(.RESET_MIN_CYCLES(8)) u_module_end (.ref_clk_in(clk), .resetn_in(rstn),
    .link(lk.module_mp), .fault_in(fault), .power_limit_low_out(pl), .control_out(ctl),
    .in_reset_out(inr), .status_pending_out(pnd));
  host_end u_host_end (.ref_clk_in(clk), .resetn_in(rstn), .link(lk.host_mp),
    .cmd_valid_in(cv), .cmd_read_in(crd), .cmd_reg_in(ca), .cmd_wdata_in(cd),
    .cmd_ready_out(rdy), .rsp_valid_out(rv), .rsp_nack_out(nk), .rsp_rdata_out(rdat),
    .reset_req_in(rreq), .low_power_in(lp), .present_out(prs), .irq_out(irq),
    .status_valid_out(sv));
  sideband_assertions #(.RESET_MIN_CYCLES(8)) u_chk (.ref_clk_in(clk), .resetn_in(rstn),
    .module_select_n(lk.module_select_n), .module_reset_n(lk.module_reset_n),
    .scl(lk.scl), .presence_n(lk.presence_n), .interrupt_n(lk.interrupt_n),
    .mod_sda_out(lk.mod_sda_out), .mod_sda_oe(lk.mod_sda_oe),
    .mod_int_out(lk.mod_int_out), .mod_int_oe(lk.mod_int_oe));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait, the level reached is itself compared
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, s}, {7'h0, v});
  endtask
  task automatic op(input logic r, input logic [7:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cv <= 1'h1;
    crd <= r;
    ca <= ad;
    cd <= d;
    @(posedge clk);
    cv <= 1'h0;
    while (rv !== 1'h1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, rv}, 8'h01);
    chk({7'h0, nk}, 8'h00);
    if (r) chk(rdat, mem[ad]);
    // status and flags bytes are read only, flags clear on read
    if (!r && ad != 8'h02 && ad != 8'h03) mem[ad] = d;
    if (r && ad == 8'h03) mem[3] = 8'h00;
  endtask
  ////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    mem[3] = 8'h01;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    wt(irq, 1'h1);
    chk({7'h0, prs}, 8'h01);
    chk({7'h0, pnd}, 8'h00);
    chk({7'h0, inr}, 8'h00);
    wt(pl, 1'h0);
    @(posedge clk);
    lp <= 1'h1;
    wt(pl, 1'h1);
    @(posedge clk);
    lp <= 1'h0;
    wt(pl, 1'h0);
    op(1'h1, 8'h03, 8'h00);
    wt(irq, 1'h0);
    a = {2'h0, 6'($random(seed))} + 8'h10;
    op(1'h0, a, 8'($random(seed)));
    op(1'h0, 8'h02, 8'h5A);
    op(1'h1, a, 8'h00);
    op(1'h1, 8'h02, 8'h00);
    op(1'h0, 8'h5D, 8'h01);
    chk(ctl, 8'h01);
    wt(pl, 1'h1);
    @(posedge clk);
    fault <= 1'h1;
    wt(irq, 1'h1);
    @(posedge clk);
    fault <= 1'h0;
    rreq <= 1'h1;
    @(posedge clk);
    rreq <= 1'h0;
    wt(sv, 1'h0);
    chk({7'h0, rdy}, 8'h00);
    wt(inr, 1'h1);
    chk({7'h0, pnd}, 8'h01);
    wt(sv, 1'h1);
    chk({7'h0, pnd}, 8'h00);
    chk({7'h0, inr}, 8'h00);
    chk(ctl, 8'h00);
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    mem[3] = 8'h01;
    wt(pl, 1'h0);
    op(1'h1, a, 8'h00);
    op(1'h1, 8'h03, 8'h00);
    wrap_up();
  end
  initial begin
    #900000;
    errors++;
    wrap_up();
  end
endmodule // testbench
